// [cod_regs.svh]
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

// Whole first-byte codes, plus the base byte that follows the ASCII multiply and divide codes
`define COD_SEG_LOAD        8'h8E
`define COD_SEG_STORE       8'h8C
`define COD_TABLE_LOOKUP    8'hD7
`define COD_EA_LOAD         8'h8D
`define COD_PTR_DATA_SEG    8'hC5
`define COD_PTR_EXTRA_SEG   8'hC4
`define COD_FLAGS_TO_HIGH   8'h9F
`define COD_HIGH_TO_FLAGS   8'h9E
`define COD_FLAGS_PUSH      8'h9C
`define COD_FLAGS_POP       8'h9D
`define COD_ASCII_ADD       8'h37
`define COD_ASCII_SUB       8'h3F
`define COD_BCD_ADD         8'h27
`define COD_BCD_SUB         8'h2F
`define COD_ASCII_MULT      8'hD4
`define COD_ASCII_DIV       8'hD5
`define COD_ASCII_BASE      8'h0A
`define COD_BYTE_TO_WORD    8'h98
`define COD_WORD_TO_DOUBLE  8'h99

// Partial first-byte codes, top six or seven bits
`define COD_ADC_RM_HI6      6'h04
`define COD_SBB_RM_HI6      6'h06
`define COD_IMM_GRP_HI6     6'h20
`define COD_SHIFT_GRP_HI6   6'h34
`define COD_ADC_ACC_HI7     7'h0A
`define COD_SBB_ACC_HI7     7'h0E
`define COD_UNARY_GRP_HI7   7'h7B

// Extension field values
`define COD_EXT_ADC         3'h2
`define COD_EXT_SBB         3'h3
`define COD_EXT_INVERT      3'h2
`define COD_EXT_SIGN_CHG    3'h3
`define COD_EXT_UMUL        3'h4
`define COD_EXT_SMUL        3'h5
`define COD_EXT_UDIV        3'h6
`define COD_EXT_SDIV        3'h7
`define COD_EXT_ROL         3'h0
`define COD_EXT_ROR         3'h1
`define COD_EXT_RCL         3'h2
`define COD_EXT_SHL         3'h4
`define COD_EXT_SHR         3'h5
`define COD_EXT_SAR         3'h7

// Field positions in the addressing byte
`define COD_MOD_HI          7
`define COD_MOD_LO          6
`define COD_EXT_HI          5
`define COD_EXT_LO          3
`define COD_RM_HI           2
`define COD_RM_LO           0

// Addressing kinds and direct address locator
`define COD_MOD_NO_DISP     2'h0
`define COD_MOD_DISP8       2'h1
`define COD_MOD_DISP16      2'h2
`define COD_RM_DIRECT       3'h6

// Lengths in bytes
`define COD_LEN_ONE         3'h1
`define COD_LEN_TWO         3'h2

`endif

// [cod_pkg.sv]
package cod_pkg;

    typedef enum logic [5:0] {
        COD_OP_NONE,
        COD_OP_TRANSFER_TO_SEG,
        COD_OP_TRANSFER_FROM_SEG,
        COD_OP_TABLE_BYTE_LOOKUP,
        COD_OP_EFFECTIVE_ADDRESS_LOAD,
        COD_OP_POINTER_LOAD_DATA_SEG,
        COD_OP_POINTER_LOAD_EXTRA_SEG,
        COD_OP_FLAGS_TO_HIGH_ACC,
        COD_OP_HIGH_ACC_TO_FLAGS,
        COD_OP_FLAGS_PUSH,
        COD_OP_FLAGS_POP,
        COD_OP_ADD_CARRY,
        COD_OP_SUB_BORROW,
        COD_OP_ASCII_ADD_ADJUST,
        COD_OP_ASCII_SUB_ADJUST,
        COD_OP_BCD_ADD_ADJUST,
        COD_OP_BCD_SUB_ADJUST,
        COD_OP_ASCII_MULT_ADJUST,
        COD_OP_ASCII_DIV_ADJUST,
        COD_OP_INVERT,
        COD_OP_SIGN_CHANGE,
        COD_OP_UNSIGNED_PRODUCT,
        COD_OP_SIGNED_PRODUCT,
        COD_OP_UNSIGNED_QUOTIENT,
        COD_OP_SIGNED_QUOTIENT,
        COD_OP_BYTE_TO_WORD_EXTEND,
        COD_OP_WORD_TO_DOUBLE_EXTEND,
        COD_OP_LEFT_ROTATE,
        COD_OP_RIGHT_ROTATE,
        COD_OP_LEFT_ROTATE_THROUGH_CARRY,
        COD_OP_LEFT_SHIFT,
        COD_OP_LOGICAL_RIGHT_SHIFT,
        COD_OP_ARITH_RIGHT_SHIFT,
        COD_OP_UNKNOWN
    } cod_op_e;

    typedef enum logic {
        COD_ST_FIRST,
        COD_ST_SECOND
    } cod_state_e;

endpackage

// [cod_disp_len.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.svh"

module cod_disp_len (
    // Addressing byte
    input  wire logic [7:0] modrm_in,
    // Displacement bytes that follow it
    output logic      [1:0] disp_len_out
);

    logic [1:0] mode;
    logic [2:0] locator;
    logic       direct;

    assign mode    = modrm_in[`COD_MOD_HI:`COD_MOD_LO];
    assign locator = modrm_in[`COD_RM_HI:`COD_RM_LO];
    assign direct  = (mode == `COD_MOD_NO_DISP) && (locator == `COD_RM_DIRECT);

    // Direct address mode carries a 16-bit address despite mode zero
    assign disp_len_out = direct                     ? 2'h2 :
                          (mode == `COD_MOD_DISP8)  ? 2'h1 :
                          (mode == `COD_MOD_DISP16) ? 2'h2 : 2'h0;

endmodule
`default_nettype wire

// [cod_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.svh"

module cod_decoder (
    // Clock and reset
    input  wire logic           sys_clk_in,
    input  wire logic           nrst_in,
    // Byte stream from the fetch queue
    input  wire logic           byte_valid_in,
    input  wire logic [7:0]     byte_in,
    // Decoded instruction
    output logic                decode_valid_out,
    output cod_pkg::cod_op_e    op_out,
    output logic      [2:0]     length_out,
    output logic                word_out,
    output logic                to_reg_out,
    output logic                count_by_cl_out,
    output logic                sign_ext_out,
    output logic      [1:0]     seg_sel_out,
    output logic      [7:0]     modrm_out,
    output logic                unknown_out
);
    import cod_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Byte selection

    cod_state_e state_q;
    cod_state_e state_d;
    logic [7:0] first_q;
    logic [7:0] opc;
    logic [2:0] ext;
    logic [1:0] disp_len;
    logic       in_second;

    assign in_second = (state_q == COD_ST_SECOND);
    assign opc       = in_second ? first_q : byte_in;
    assign ext       = byte_in[`COD_EXT_HI:`COD_EXT_LO];

    cod_disp_len u_disp_len (
        .modrm_in     (byte_in),
        .disp_len_out (disp_len)
    );

    ////////////////////////////////////////////////////////////////////////////
    // First-byte classes

    logic is_seg_load;
    logic is_seg_store;
    logic is_ea_load;
    logic is_ptr_data;
    logic is_ptr_extra;
    logic is_adc_rm;
    logic is_sbb_rm;
    logic is_imm_grp;
    logic is_unary_grp;
    logic is_shift_grp;
    logic is_ascii_mult;
    logic is_ascii_div;
    logic is_adc_acc;
    logic is_sbb_acc;
    logic needs_second;
    logic has_modrm;

    assign is_seg_load   = (opc == `COD_SEG_LOAD);
    assign is_seg_store  = (opc == `COD_SEG_STORE);
    assign is_ea_load    = (opc == `COD_EA_LOAD);
    assign is_ptr_data   = (opc == `COD_PTR_DATA_SEG);
    assign is_ptr_extra  = (opc == `COD_PTR_EXTRA_SEG);
    assign is_adc_rm     = (opc[7:2] == `COD_ADC_RM_HI6);
    assign is_sbb_rm     = (opc[7:2] == `COD_SBB_RM_HI6);
    assign is_imm_grp    = (opc[7:2] == `COD_IMM_GRP_HI6);
    assign is_unary_grp  = (opc[7:1] == `COD_UNARY_GRP_HI7);
    assign is_shift_grp  = (opc[7:2] == `COD_SHIFT_GRP_HI6);
    assign is_ascii_mult = (opc == `COD_ASCII_MULT);
    assign is_ascii_div  = (opc == `COD_ASCII_DIV);
    assign is_adc_acc    = (opc[7:1] == `COD_ADC_ACC_HI7);
    assign is_sbb_acc    = (opc[7:1] == `COD_SBB_ACC_HI7);

    assign has_modrm    = is_seg_load | is_seg_store | is_ea_load | is_ptr_data
                        | is_ptr_extra | is_adc_rm | is_sbb_rm | is_imm_grp
                        | is_unary_grp | is_shift_grp;
    assign needs_second = has_modrm | is_ascii_mult | is_ascii_div;

    ////////////////////////////////////////////////////////////////////////////
    // Operation selection

    cod_op_e op_one;
    cod_op_e op_two;

    always_comb begin
        case (opc)
            `COD_TABLE_LOOKUP:   op_one = COD_OP_TABLE_BYTE_LOOKUP;
            `COD_FLAGS_TO_HIGH:  op_one = COD_OP_FLAGS_TO_HIGH_ACC;
            `COD_HIGH_TO_FLAGS:  op_one = COD_OP_HIGH_ACC_TO_FLAGS;
            `COD_FLAGS_PUSH:     op_one = COD_OP_FLAGS_PUSH;
            `COD_FLAGS_POP:      op_one = COD_OP_FLAGS_POP;
            `COD_ASCII_ADD:      op_one = COD_OP_ASCII_ADD_ADJUST;
            `COD_ASCII_SUB:      op_one = COD_OP_ASCII_SUB_ADJUST;
            `COD_BCD_ADD:        op_one = COD_OP_BCD_ADD_ADJUST;
            `COD_BCD_SUB:        op_one = COD_OP_BCD_SUB_ADJUST;
            `COD_BYTE_TO_WORD:   op_one = COD_OP_BYTE_TO_WORD_EXTEND;
            `COD_WORD_TO_DOUBLE: op_one = COD_OP_WORD_TO_DOUBLE_EXTEND;
            default: begin
                if (is_adc_acc) begin
                    op_one = COD_OP_ADD_CARRY;
                end else if (is_sbb_acc) begin
                    op_one = COD_OP_SUB_BORROW;
                end else begin
                    op_one = COD_OP_UNKNOWN;
                end
            end
        endcase
    end

    // Group codes not owned by this block decode as unknown
    always_comb begin
        op_two = COD_OP_UNKNOWN;
        if (is_seg_load) begin
            op_two = byte_in[`COD_EXT_HI] ? COD_OP_UNKNOWN : COD_OP_TRANSFER_TO_SEG;
        end else if (is_seg_store) begin
            op_two = byte_in[`COD_EXT_HI] ? COD_OP_UNKNOWN : COD_OP_TRANSFER_FROM_SEG;
        end else if (is_ea_load) begin
            op_two = COD_OP_EFFECTIVE_ADDRESS_LOAD;
        end else if (is_ptr_data) begin
            op_two = COD_OP_POINTER_LOAD_DATA_SEG;
        end else if (is_ptr_extra) begin
            op_two = COD_OP_POINTER_LOAD_EXTRA_SEG;
        end else if (is_adc_rm) begin
            op_two = COD_OP_ADD_CARRY;
        end else if (is_sbb_rm) begin
            op_two = COD_OP_SUB_BORROW;
        end else if (is_imm_grp) begin
            case (ext)
                `COD_EXT_ADC: op_two = COD_OP_ADD_CARRY;
                `COD_EXT_SBB: op_two = COD_OP_SUB_BORROW;
                default:      op_two = COD_OP_UNKNOWN;
            endcase
        end else if (is_unary_grp) begin
            case (ext)
                `COD_EXT_INVERT:   op_two = COD_OP_INVERT;
                `COD_EXT_SIGN_CHG: op_two = COD_OP_SIGN_CHANGE;
                `COD_EXT_UMUL:     op_two = COD_OP_UNSIGNED_PRODUCT;
                `COD_EXT_SMUL:     op_two = COD_OP_SIGNED_PRODUCT;
                `COD_EXT_UDIV:     op_two = COD_OP_UNSIGNED_QUOTIENT;
                `COD_EXT_SDIV:     op_two = COD_OP_SIGNED_QUOTIENT;
                default:           op_two = COD_OP_UNKNOWN;
            endcase
        end else if (is_shift_grp) begin
            case (ext)
                `COD_EXT_ROL: op_two = COD_OP_LEFT_ROTATE;
                `COD_EXT_ROR: op_two = COD_OP_RIGHT_ROTATE;
                `COD_EXT_RCL: op_two = COD_OP_LEFT_ROTATE_THROUGH_CARRY;
                `COD_EXT_SHL: op_two = COD_OP_LEFT_SHIFT;
                `COD_EXT_SHR: op_two = COD_OP_LOGICAL_RIGHT_SHIFT;
                `COD_EXT_SAR: op_two = COD_OP_ARITH_RIGHT_SHIFT;
                default:      op_two = COD_OP_UNKNOWN;
            endcase
        end else if (is_ascii_mult) begin
            op_two = (byte_in == `COD_ASCII_BASE) ? COD_OP_ASCII_MULT_ADJUST
                                                  : COD_OP_UNKNOWN;
        end else if (is_ascii_div) begin
            op_two = (byte_in == `COD_ASCII_BASE) ? COD_OP_ASCII_DIV_ADJUST
                                                  : COD_OP_UNKNOWN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Length and operand attributes

    logic [2:0] imm_len;
    logic [2:0] len_one;
    logic [2:0] len_two;
    logic       imm_two;
    logic       has_dw;

    // Immediate group widens only for s:w of 01; s:w 11 sign-extends one byte
    assign imm_two = (opc[1:0] == 2'h1);
    assign imm_len = is_imm_grp ? (imm_two ? 3'h2 : 3'h1) : 3'h0;
    assign len_one = (is_adc_acc | is_sbb_acc)
                   ? (opc[0] ? 3'h3 : `COD_LEN_TWO) : `COD_LEN_ONE;
    assign len_two = has_modrm ? 3'(`COD_LEN_TWO + {1'b0, disp_len} + imm_len)
                               : `COD_LEN_TWO;
    assign has_dw  = is_adc_rm | is_sbb_rm;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencing

    logic fire;

    assign fire    = byte_valid_in & (in_second | ~needs_second);
    assign state_d = ~byte_valid_in ? state_q :
                     in_second      ? COD_ST_FIRST :
                     needs_second   ? COD_ST_SECOND : COD_ST_FIRST;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= COD_ST_FIRST;
            first_q <= 8'h00;
        end else begin
            state_q <= state_d;
            first_q <= (byte_valid_in & ~in_second) ? byte_in : first_q;
        end
    end

    // Attributes hold until the next decode so the datapath may sample late
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            decode_valid_out <= 1'b0;
            op_out           <= COD_OP_NONE;
            length_out       <= 3'h0;
            word_out         <= 1'b0;
            to_reg_out       <= 1'b0;
            count_by_cl_out  <= 1'b0;
            sign_ext_out     <= 1'b0;
            seg_sel_out      <= 2'h0;
            modrm_out        <= 8'h00;
            unknown_out      <= 1'b0;
        end else begin
            decode_valid_out <= fire;
            if (fire) begin
                op_out          <= in_second ? op_two : op_one;
                length_out      <= in_second ? len_two : len_one;
                word_out        <= (has_dw | is_imm_grp | is_unary_grp | is_shift_grp
                                    | is_adc_acc | is_sbb_acc) & opc[0];
                to_reg_out      <= has_dw & opc[1];
                count_by_cl_out <= is_shift_grp & opc[1];
                sign_ext_out    <= is_imm_grp & opc[1];
                seg_sel_out     <= (is_seg_load | is_seg_store)
                                   ? byte_in[`COD_EXT_LO+1:`COD_EXT_LO] : 2'h0;
                modrm_out       <= in_second ? byte_in : 8'h00;
                unknown_out     <= in_second ? (op_two == COD_OP_UNKNOWN)
                                             : (op_one == COD_OP_UNKNOWN);
            end
        end
    end

endmodule
`default_nettype wire

// [cod_decoder_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.svh"
module cod_checker
    import cod_pkg::*;
(
    // Clock and reset
    input wire logic                sys_clk_in,
    input wire logic                nrst_in,
    // Byte stream
    input wire logic                byte_valid_in,
    input wire logic [7:0]          byte_in,
    // Decode outputs
    input wire logic                decode_valid_out,
    input wire cod_pkg::cod_op_e    op_out,
    input wire logic [2:0]          length_out,
    input wire logic                word_out,
    input wire logic                to_reg_out,
    input wire logic                count_by_cl_out,
    input wire logic                sign_ext_out,
    input wire logic [1:0]          seg_sel_out,
    input wire logic [7:0]          modrm_out,
    input wire logic                unknown_out
);
    ////////////////////////////////////////////////////////////////////////
    // Own copy of the byte position, so outputs are judged against inputs
    logic sec_q;
    logic sec_d;
    wire  first_w = !sec_q;
    wire  take1_w = first_w && byte_valid_in;
    wire  two_w   = (byte_in inside {8'h8E, 8'h8C, 8'h8D, 8'hC5, 8'hC4, 8'hD4, 8'hD5})
                  || (byte_in[7:2] inside {6'h04, 6'h06, 6'h20, 6'h34})
                  || (byte_in[7:1] == 7'h7B);
    assign sec_d = byte_valid_in ? (first_w && two_w) : sec_q;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sec_q <= 1'b0;
        end else begin
            sec_q <= sec_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_aam;
        take1_w && byte_in == 8'hD4 ##1 byte_valid_in && byte_in == 8'h0A;
    endsequence
    sequence s_sbb;
        take1_w && byte_in == 8'h83 ##1 byte_valid_in && byte_in[7:3] == 5'h1B;
    endsequence
    sequence s_shl;
        take1_w && byte_in[7:2] == 6'h34 ##1 byte_valid_in && byte_in[5:3] == 3'h4;
    endsequence
    sequence s_seg;
        take1_w && byte_in == 8'h8E ##1 byte_valid_in && !byte_in[5];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    lookup_one_a: assert property (
        take1_w && byte_in == 8'hD7 |=> decode_valid_out
            && op_out == COD_OP_TABLE_BYTE_LOOKUP && length_out == 3'h1)
        else $error("table lookup decode wrong");
    flags_push_a: assert property (
        take1_w && byte_in == 8'h9C |=> decode_valid_out && op_out == COD_OP_FLAGS_PUSH)
        else $error("flag push decode wrong");
    pair_wait_a: assert property (
        take1_w && two_w |=> !decode_valid_out)
        else $error("decode before second byte");
    ascii_mult_a: assert property (
        s_aam |=> decode_valid_out && op_out == COD_OP_ASCII_MULT_ADJUST && length_out == 3'h2)
        else $error("ascii multiply adjust wrong");
    sbb_imm_a: assert property (
        s_sbb |=> op_out == COD_OP_SUB_BORROW && length_out == 3'h3 && sign_ext_out && word_out)
        else $error("borrow immediate decode wrong");
    shift_left_a: assert property (
        s_shl |=> op_out == COD_OP_LEFT_SHIFT && count_by_cl_out == $past(byte_in[1], 2)
            && word_out == $past(byte_in[0], 2))
        else $error("left shift decode wrong");
    seg_select_a: assert property (
        s_seg |=> op_out == COD_OP_TRANSFER_TO_SEG && seg_sel_out == $past(byte_in[4:3]))
        else $error("segment select wrong");
    hold_value_a: assert property (
        !decode_valid_out |-> $stable(op_out) && $stable(length_out) && $stable(modrm_out))
        else $error("outputs moved without decode");
endmodule
bind cod_decoder cod_checker chk_i (.sys_clk_in, .nrst_in, .byte_valid_in, .byte_in,
    .decode_valid_out, .op_out, .length_out, .word_out, .to_reg_out, .count_by_cl_out,
    .sign_ext_out, .seg_sel_out, .modrm_out, .unknown_out);
`default_nettype wire

// [cod_fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cod_fetch_model (
    // Clock
    input  wire logic       sys_clk_in,
    // Byte stream to the decoder
    output var  logic       byte_valid_out,
    output var  logic [7:0] byte_out
);
    initial begin
        byte_valid_out = 1'b0;
        byte_out = 8'h00;
    end
    // Released bus flips each idle cycle; the last byte shows again on every second one
    task automatic idle();
        byte_valid_out = 1'b0;
        byte_out = ~byte_out;
        @(negedge sys_clk_in);
    endtask
    task automatic put(input logic [7:0] b);
        byte_valid_out = 1'b1;
        byte_out = b;
        @(negedge sys_clk_in);
    endtask
    // Only opcode and addressing byte go out; the rest is skipped by length
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input int n, input int gap);
        put(b0);
        if (n == 2) begin
            repeat (gap) idle();
            put(b1);
        end
        // Lowered without a wait so the caller still sees the one-cycle pulse
        byte_valid_out = 1'b0;
        byte_out = ~byte_out;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cod_pkg::*;
    logic       sys_clk_in;
    logic       nrst_in;
    wire logic  byte_valid_w;
    wire logic [7:0] byte_w;
    logic       decode_valid_out;
    cod_op_e    op_out;
    logic [2:0] length_out;
    logic       word_out;
    logic       to_reg_out;
    logic       count_by_cl_out;
    logic       sign_ext_out;
    logic [1:0] seg_sel_out;
    logic [7:0] modrm_out;
    logic       unknown_out;
    int         num_errors;
    int         total_checks;
    cod_fetch_model fm (.sys_clk_in, .byte_valid_out(byte_valid_w), .byte_out(byte_w));
    cod_decoder dut (.sys_clk_in, .nrst_in, .byte_valid_in(byte_valid_w), .byte_in(byte_w),
        .decode_valid_out, .op_out, .length_out, .word_out, .to_reg_out, .count_by_cl_out,
        .sign_ext_out, .seg_sel_out, .modrm_out, .unknown_out);
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Side fields worked out from the opcode bits and the addressing byte
    task automatic run_one(input logic [7:0] b0, input logic [7:0] b1, input int n,
                           input int gap, input cod_op_e op, input logic [2:0] len);
        logic w;
        int i;
        w = (b0[7:2] inside {6'h04, 6'h06, 6'h20, 6'h34} || b0[7:1] inside {7'h0A, 7'h0E, 7'h7B})
            ? b0[0] : 1'b0;
        fm.send(b0, b1, n, gap);
        i = 0;
        while (decode_valid_out !== 1'b1 && i < 4) begin
            @(negedge sys_clk_in);
            i++;
        end
        if (decode_valid_out !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t no decode", $time);
            finish_test();
        end else begin
            check(32'(op_out), 32'(op));
            check(32'(length_out), 32'(len));
            check(32'(word_out), 32'(w));
            check(32'(to_reg_out), 32'(b0[7:2] inside {6'h04, 6'h06} ? b0[1] : 1'b0));
            check(32'(sign_ext_out), 32'(b0[7:2] == 6'h20 ? b0[1] : 1'b0));
            check(32'(count_by_cl_out), 32'(b0[7:2] == 6'h34 ? b0[1] : 1'b0));
            check(32'(seg_sel_out), 32'(b0 inside {8'h8E, 8'h8C} ? b1[4:3] : 2'h0));
            check(32'(modrm_out), 32'(n == 2 ? b1 : 8'h00));
            check(32'(unknown_out), 32'(op == COD_OP_UNKNOWN));
        end
        @(negedge sys_clk_in);
        check(32'(decode_valid_out), 32'h0);
        check(32'(op_out), 32'(op));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_single();
        logic [7:0] c [12] = '{8'hD7, 8'h9F, 8'h9E, 8'h9C, 8'h9D, 8'h37,
                              8'h3F, 8'h27, 8'h2F, 8'h98, 8'h99, 8'hF4};
        cod_op_e e [12] = '{COD_OP_TABLE_BYTE_LOOKUP, COD_OP_FLAGS_TO_HIGH_ACC,
            COD_OP_HIGH_ACC_TO_FLAGS, COD_OP_FLAGS_PUSH, COD_OP_FLAGS_POP,
            COD_OP_ASCII_ADD_ADJUST, COD_OP_ASCII_SUB_ADJUST, COD_OP_BCD_ADD_ADJUST,
            COD_OP_BCD_SUB_ADJUST, COD_OP_BYTE_TO_WORD_EXTEND,
            COD_OP_WORD_TO_DOUBLE_EXTEND, COD_OP_UNKNOWN};
        for (int k = 0; k < 12; k++) begin
            run_one(c[k], 8'h00, 1, 0, e[k], 3'h1);
        end
    endtask
    task automatic t_transfer();
        run_one(8'h8E, 8'h18, 2, 0, COD_OP_TRANSFER_TO_SEG, 3'h2);
        run_one(8'h8C, 8'h46, 2, 2, COD_OP_TRANSFER_FROM_SEG, 3'h3);
        run_one(8'h8E, 8'h20, 2, 0, COD_OP_UNKNOWN, 3'h2);
        run_one(8'h8D, 8'h06, 2, 1, COD_OP_EFFECTIVE_ADDRESS_LOAD, 3'h4);
        run_one(8'hC5, 8'h80, 2, 0, COD_OP_POINTER_LOAD_DATA_SEG, 3'h4);
        run_one(8'hC4, 8'hC7, 2, 0, COD_OP_POINTER_LOAD_EXTRA_SEG, 3'h2);
    endtask
    task automatic t_arith();
        run_one(8'h13, 8'hC1, 2, 0, COD_OP_ADD_CARRY, 3'h2);
        run_one(8'h81, 8'h56, 2, 0, COD_OP_ADD_CARRY, 3'h5);
        run_one(8'h15, 8'h00, 1, 0, COD_OP_ADD_CARRY, 3'h3);
        run_one(8'h83, 8'hDB, 2, 0, COD_OP_SUB_BORROW, 3'h3);
        run_one(8'h80, 8'h5E, 2, 1, COD_OP_SUB_BORROW, 3'h4);
        run_one(8'h1A, 8'hC0, 2, 0, COD_OP_SUB_BORROW, 3'h2);
        run_one(8'h1C, 8'h00, 1, 0, COD_OP_SUB_BORROW, 3'h2);
        run_one(8'h81, 8'hE0, 2, 0, COD_OP_UNKNOWN, 3'h4);
    endtask
    task automatic t_adjust();
        run_one(8'hD4, 8'h0A, 2, 0, COD_OP_ASCII_MULT_ADJUST, 3'h2);
        run_one(8'hD5, 8'h0A, 2, 3, COD_OP_ASCII_DIV_ADJUST, 3'h2);
        run_one(8'hD4, 8'h0B, 2, 0, COD_OP_UNKNOWN, 3'h2);
    endtask
    task automatic t_groups();
        cod_op_e u [6] = '{COD_OP_INVERT, COD_OP_SIGN_CHANGE, COD_OP_UNSIGNED_PRODUCT,
            COD_OP_SIGNED_PRODUCT, COD_OP_UNSIGNED_QUOTIENT, COD_OP_SIGNED_QUOTIENT};
        logic [2:0] x [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
        cod_op_e s [6] = '{COD_OP_LEFT_ROTATE, COD_OP_RIGHT_ROTATE,
            COD_OP_LEFT_ROTATE_THROUGH_CARRY, COD_OP_LEFT_SHIFT,
            COD_OP_LOGICAL_RIGHT_SHIFT, COD_OP_ARITH_RIGHT_SHIFT};
        for (int k = 0; k < 6; k++) begin
            run_one(8'hF7, {2'h3, 3'(k + 2), 3'h0}, 2, 0, u[k], 3'h2);
            run_one(k[0] ? 8'hD3 : 8'hD0, {2'h3, x[k], 3'h1}, 2, 0, s[k], 3'h2);
        end
        run_one(8'hF6, 8'hC0, 2, 0, COD_OP_UNKNOWN, 3'h2);
        run_one(8'hD2, 8'hD8, 2, 0, COD_OP_UNKNOWN, 3'h2);
    endtask
    // Reset in mid instruction must leave the decoder waiting for a first byte
    task automatic t_reset();
        fm.send(8'h81, 8'h00, 1, 0);
        nrst_in = 1'b0;
        @(negedge sys_clk_in);
        check(32'(decode_valid_out), 32'h0);
        check(32'(op_out), 32'(COD_OP_NONE));
        check(32'(length_out), 32'h0);
        nrst_in = 1'b1;
        @(negedge sys_clk_in);
        run_one(8'hD7, 8'h00, 1, 0, COD_OP_TABLE_BYTE_LOOKUP, 3'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        total_checks = 0;
        nrst_in = 1'b0;
        repeat (8) @(negedge sys_clk_in);
        nrst_in = 1'b1;
        @(negedge sys_clk_in);
        t_single();
        t_transfer();
        t_arith();
        t_adjust();
        t_groups();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
